// *** pkg/irpa_pkg.sv ***
// Shared constants for the LED driver register front end and its bus master.
// Assumes a single 50 MHz clock on both ends of the two-wire link.
package irpa_pkg;
  localparam int unsigned CLK_MHZ = 50;
  // Link clock half period, a least time in ns
  localparam int unsigned T_HALF_NS = 500;
  localparam int unsigned HALF_CYC = (T_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0] HALF_M1 = 6'(HALF_CYC - 1);

  // Register indices
  localparam logic [4:0] IDX_MODE_CONFIG_FIRST = 5'h00;
  localparam logic [4:0] IDX_MODE_CONFIG_SECOND = 5'h01;
  localparam logic [4:0] IDX_CHANNEL0_BRIGHTNESS = 5'h02;
  localparam logic [4:0] IDX_CHANNEL7_BRIGHTNESS = 5'h09;
  localparam logic [4:0] IDX_GROUP_DUTY_CYCLE = 5'h0a;
  localparam logic [4:0] IDX_GROUP_FREQUENCY = 5'h0b;
  localparam logic [4:0] IDX_OUTPUT_STATE_LOW = 5'h0c;
  localparam logic [4:0] IDX_OUTPUT_STATE_HIGH = 5'h0d;
  localparam logic [4:0] IDX_SUB_CALL_ADDRESS_ONE = 5'h0e;
  localparam logic [4:0] IDX_SUB_CALL_ADDRESS_TWO = 5'h0f;
  localparam logic [4:0] IDX_SUB_CALL_ADDRESS_THREE = 5'h10;
  localparam logic [4:0] IDX_BROADCAST_CALL_ADDRESS = 5'h11;
  localparam logic [4:0] IDX_CURRENT_GAIN_CONFIG = 5'h12;
  localparam logic [4:0] IDX_FAULT_FLAGS = 5'h13;
  localparam logic [4:0] IDX_TOP = 5'h1b;
  localparam int unsigned REG_COUNT = 19;

  // Auto-increment turning points
  localparam logic [4:0] LAST_BRIGHT = 5'h11;
  localparam logic [4:0] LAST_GROUP = 5'h13;
  localparam logic [4:0] ROLL_ALL = 5'h00;
  localparam logic [4:0] ROLL_BRIGHT = 5'h02;
  localparam logic [4:0] ROLL_GROUP = 5'h12;

  // Reset values of the writable registers, index 0 upward
  localparam logic [7:0] REG_RST [REG_COUNT] = '{
    8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h92, 8'h94, 8'h98, 8'h90, 8'h00};

  // Enable bits in mode_config_first
  localparam int unsigned BIT_SUB1_EN = 3;
  localparam int unsigned BIT_SUB2_EN = 2;
  localparam int unsigned BIT_SUB3_EN = 1;
  localparam int unsigned BIT_ALLCALL_EN = 0;

  // Reserved soft reset call address, value is arbitrary
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h4b;

  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;

  typedef enum logic [2:0] {
    AI_NONE = 3'h0, AI_ALL = 3'h4, AI_BRIGHT = 3'h5, AI_GROUP = 3'h6, AI_BOTH = 3'h7
  } irpa_scheme_t;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h0, DS_ADDR = 3'h1, DS_ACK = 3'h3, DS_CTRL = 3'h2,
    DS_WDATA = 3'h6, DS_RDATA = 3'h7, DS_RACK = 3'h5, DS_WAIT = 3'h4
  } irpa_dev_st_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0, HS_START = 2'h1, HS_BIT = 2'h3, HS_STOP = 2'h2
  } irpa_host_st_t;

  // Wishbone map of the bus master
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_STAT = 8'h04;
  localparam int unsigned CMD_START = 8;
  localparam int unsigned CMD_STOP = 9;
  localparam int unsigned CMD_READ = 10;
  localparam int unsigned CMD_NACK = 11;
endpackage

// *** pkg/irpa_link_if.sv ***
// Two-wire link between the bus master and the LED driver front end.
// Both wires are open drain with pull-ups; the wire levels are resolved here.
`timescale 1ns/1ns
interface irpa_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport dev (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// *** core/irpa_device.sv ***
// LED driver register front end: two-wire slave, pointer control, register file.
// Assumes link wires synchronous to clk_i and a master that keeps its own rules.
// Operation
// - Soft reset call acknowledged on writes only
// - Reserved call never used as device address
// - Byte after address goes into pointer control
// - Low five bits select target register
// - Top three bits choose increment scheme
// - Enabled increment advances index per data byte
// - Scheme 000 keeps index fixed
// - Scheme 100 wraps 1B to 00
// - Scheme 101 wraps 11 to 02
// - Scheme 110 wraps 13 to 12
// - Scheme 111 wraps 13 to 02
// - Master never sends reserved schemes 001-011
// - Increment touches index bits only
// - Written index is first accessed register
// - Indices 00-13 decode the register map
// - Address byte bit 0 selects direction
// - Broadcast call enabled, sub-calls disabled at reset
//
// Design decision made here: register contents exposed in parallel on regs_o.
`timescale 1ns/1ns
module irpa_device (
  input wire logic clk_i,
  input wire logic rst_i,
  irpa_link_if.dev link,
  input wire logic [6:0] slave_addr_i,
  input wire logic [7:0] fault_i,
  output logic [irpa_pkg::REG_COUNT-1:0][7:0] regs_o,
  output logic [7:0] pointer_o
);
  irpa_pkg::irpa_dev_st_t st_r;
  irpa_pkg::irpa_dev_st_t after_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] ctrl_r;
  logic [3:0] cnt_r;
  logic oe_r;
  logic sreset_pend_r;
  logic [7:0] regs_r [irpa_pkg::REG_COUNT];
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic soft_rst;
  logic wr_en;
  logic [7:0] rx_byte;
  logic [7:0] rd_now;
  logic [4:0] idx_nxt;
  logic [3:0] tsel;
  logic hit_dev;
  logic hit_sreset;
  logic [7:0] mode_cfg;

  // Edge and condition detection on the link wires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= link.scl;
      sda_q_r <= link.sda;
    end
  end

  assign rise = link.scl & ~scl_q_r;
  assign fall = ~link.scl & scl_q_r;
  assign start = link.scl & scl_q_r & sda_q_r & ~link.sda;
  assign stop = link.scl & scl_q_r & ~sda_q_r & link.sda;
  assign rx_byte = {sh_r[6:0], link.sda};
  assign tsel = irpa_pkg::BYTE_LAST - cnt_r;
  assign mode_cfg = regs_r[irpa_pkg::IDX_MODE_CONFIG_FIRST];

  // Address match; the direction bit is the byte's last bit
  always_comb begin
    hit_sreset = (rx_byte[7:1] == irpa_pkg::SOFT_RESET_ADDR) & ~rx_byte[0];
    hit_dev = (rx_byte[7:1] == slave_addr_i);
    // Enable bits come out of reset as broadcast on, sub-calls off
    if (mode_cfg[irpa_pkg::BIT_ALLCALL_EN] &&
        rx_byte[7:1] == regs_r[irpa_pkg::IDX_BROADCAST_CALL_ADDRESS][7:1]) begin
      hit_dev = 1'b1;
    end
    if (mode_cfg[irpa_pkg::BIT_SUB1_EN] &&
        rx_byte[7:1] == regs_r[irpa_pkg::IDX_SUB_CALL_ADDRESS_ONE][7:1]) begin
      hit_dev = 1'b1;
    end
    if (mode_cfg[irpa_pkg::BIT_SUB2_EN] &&
        rx_byte[7:1] == regs_r[irpa_pkg::IDX_SUB_CALL_ADDRESS_TWO][7:1]) begin
      hit_dev = 1'b1;
    end
    if (mode_cfg[irpa_pkg::BIT_SUB3_EN] &&
        rx_byte[7:1] == regs_r[irpa_pkg::IDX_SUB_CALL_ADDRESS_THREE][7:1]) begin
      hit_dev = 1'b1;
    end
  end

  // Read data selection for the current index
  always_comb begin
    if (ctrl_r[4:0] < 5'(irpa_pkg::REG_COUNT)) begin
      rd_now = regs_r[ctrl_r[4:0]];
    end else if (ctrl_r[4:0] == irpa_pkg::IDX_FAULT_FLAGS) begin
      rd_now = fault_i;
    end else begin
      rd_now = 8'h00;
    end
  end

  // Next index; an index above the scheme's last register still tops out at 1B
  always_comb begin
    idx_nxt = (ctrl_r[4:0] == irpa_pkg::IDX_TOP) ? irpa_pkg::ROLL_ALL : ctrl_r[4:0] + 5'h01;
    case (irpa_pkg::irpa_scheme_t'(ctrl_r[7:5]))
      irpa_pkg::AI_ALL: begin
      end
      irpa_pkg::AI_BRIGHT: begin
        if (ctrl_r[4:0] == irpa_pkg::LAST_BRIGHT) begin
          idx_nxt = irpa_pkg::ROLL_BRIGHT;
        end
      end
      irpa_pkg::AI_GROUP: begin
        if (ctrl_r[4:0] == irpa_pkg::LAST_GROUP) begin
          idx_nxt = irpa_pkg::ROLL_GROUP;
        end
      end
      irpa_pkg::AI_BOTH: begin
        if (ctrl_r[4:0] == irpa_pkg::LAST_GROUP) begin
          idx_nxt = irpa_pkg::ROLL_BRIGHT;
        end
      end
      // No increment, and reserved codes are treated the same way
      default: idx_nxt = ctrl_r[4:0];
    endcase
  end

  assign wr_en = (st_r == irpa_pkg::DS_WDATA) & rise & (cnt_r == irpa_pkg::BYTE_LAST);
  // The soft reset call takes effect at the stop that closes it
  assign soft_rst = stop & sreset_pend_r;

  // Link protocol engine
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      st_r <= irpa_pkg::DS_IDLE;
      after_r <= irpa_pkg::DS_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ctrl_r <= 8'h00;
      oe_r <= 1'b0;
      sreset_pend_r <= 1'b0;
    end else if (start) begin
      // A start, repeated or not, always reopens address reception
      st_r <= irpa_pkg::DS_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      sreset_pend_r <= 1'b0;
    end else if (stop) begin
      st_r <= irpa_pkg::DS_IDLE;
      oe_r <= 1'b0;
    end else begin
      if (rise) begin
        sh_r <= rx_byte;
      end
      case (st_r)
        irpa_pkg::DS_ADDR: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == irpa_pkg::BYTE_LAST) begin
              cnt_r <= 4'h0;
              if (hit_sreset) begin
                sreset_pend_r <= 1'b1;
                after_r <= irpa_pkg::DS_WAIT;
                st_r <= irpa_pkg::DS_ACK;
              end else if (hit_dev) begin
                // Reads start at the index left by earlier access
                after_r <= link.sda ? irpa_pkg::DS_RDATA : irpa_pkg::DS_CTRL;
                st_r <= irpa_pkg::DS_ACK;
              end else begin
                st_r <= irpa_pkg::DS_WAIT;
              end
            end
          end
        end
        irpa_pkg::DS_ACK: begin
          // First falling edge pulls the wire low, the second releases it or drives the first read bit
          if (fall) begin
            if (!oe_r) begin
              oe_r <= 1'b1;
            end else begin
              st_r <= after_r;
              if (after_r == irpa_pkg::DS_RDATA) begin
                tx_r <= rd_now;
                oe_r <= ~rd_now[7];
              end else begin
                oe_r <= 1'b0;
              end
            end
          end
        end
        irpa_pkg::DS_CTRL: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == irpa_pkg::BYTE_LAST) begin
              cnt_r <= 4'h0;
              ctrl_r <= rx_byte;
              after_r <= irpa_pkg::DS_WDATA;
              st_r <= irpa_pkg::DS_ACK;
            end
          end
        end
        irpa_pkg::DS_WDATA: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == irpa_pkg::BYTE_LAST) begin
              cnt_r <= 4'h0;
              ctrl_r[4:0] <= idx_nxt;
              after_r <= irpa_pkg::DS_WDATA;
              st_r <= irpa_pkg::DS_ACK;
            end
          end
        end
        irpa_pkg::DS_RDATA: begin
          if (rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == irpa_pkg::BYTE_LAST) begin
              ctrl_r[4:0] <= idx_nxt;
            end
          end else if (fall) begin
            if (cnt_r == irpa_pkg::BYTE_DONE) begin
              oe_r <= 1'b0;
              cnt_r <= 4'h0;
              st_r <= irpa_pkg::DS_RACK;
            end else begin
              oe_r <= ~tx_r[tsel[2:0]];
            end
          end
        end
        irpa_pkg::DS_RACK: begin
          // A not-acknowledge from the master ends the read burst
          if (rise && link.sda) begin
            st_r <= irpa_pkg::DS_WAIT;
          end else if (fall) begin
            tx_r <= rd_now;
            oe_r <= ~rd_now[7];
            st_r <= irpa_pkg::DS_RDATA;
          end
        end
        irpa_pkg::DS_IDLE, irpa_pkg::DS_WAIT: begin
        end
        default: st_r <= irpa_pkg::DS_IDLE;
      endcase
    end
  end

  // Register file; index 13 is read only and 14 upward hold nothing
  for (genvar g = 0; g < irpa_pkg::REG_COUNT; g++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i || soft_rst) begin
        regs_r[g] <= irpa_pkg::REG_RST[g];
      end else if (wr_en && ctrl_r[4:0] == 5'(g)) begin
        regs_r[g] <= rx_byte;
      end
    end
    assign regs_o[g] = regs_r[g];
  end

  assign pointer_o = ctrl_r;
  // Open drain: only ever pulls low
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = oe_r;
endmodule

// *** core/irpa_host.sv ***
// Bus master for the LED driver link, commanded over a classic Wishbone slave.
// Assumes it is the only master and that bytes are sequenced by software.
`timescale 1ns/1ns
module irpa_host (
  input wire logic clk_i,
  input wire logic rst_i,
  irpa_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  irpa_pkg::irpa_host_st_t st_r;
  logic [1:0] ph_r;
  logic [5:0] tmr_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic stop_f_r;
  logic read_f_r;
  logic nack_f_r;
  logic nack_seen_r;
  logic held_r;
  logic scl_low_r;
  logic sda_low_r;
  logic wb_hit;
  logic launch;
  logic bit_val;
  logic scl_low;
  logic sda_low;
  logic [3:0] tsel;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign launch = wb_hit & wb_we_i & (wb_adr_i == irpa_pkg::WB_CMD) & (&wb_sel_i[1:0]);
  assign tsel = irpa_pkg::BYTE_LAST - bit_r;

  // Wishbone slave: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= (wb_adr_i == irpa_pkg::WB_STAT) ?
          {16'h0000, rx_r, 6'h00, nack_seen_r, st_r != irpa_pkg::HS_IDLE} : 32'h0000_0000;
      end
    end
  end

  // Bit to put on the data wire; the ninth is the acknowledge slot
  always_comb begin
    if (bit_r == irpa_pkg::BYTE_DONE) begin
      bit_val = read_f_r ? nack_f_r : 1'b1;
    end else begin
      bit_val = read_f_r | tx_r[tsel[2:0]];
    end
  end

  // Wire levels per state and phase
  always_comb begin
    scl_low = held_r;
    sda_low = 1'b0;
    case (st_r)
      irpa_pkg::HS_START: begin
        scl_low = (ph_r == 2'h0) | (ph_r == 2'h3);
        sda_low = ph_r[1];
      end
      irpa_pkg::HS_BIT: begin
        scl_low = (ph_r == 2'h0);
        sda_low = ~bit_val;
      end
      irpa_pkg::HS_STOP: begin
        scl_low = (ph_r == 2'h0);
        sda_low = (ph_r != 2'h2);
      end
      default: begin
      end
    endcase
  end

  // Registered pin drive keeps outputs glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else begin
      scl_low_r <= scl_low;
      sda_low_r <= sda_low;
    end
  end

  // Byte engine; commands written while busy are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= irpa_pkg::HS_IDLE;
      ph_r <= 2'h0;
      tmr_r <= 6'h00;
      bit_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      stop_f_r <= 1'b0;
      read_f_r <= 1'b0;
      nack_f_r <= 1'b0;
      nack_seen_r <= 1'b0;
      held_r <= 1'b0;
    end else if (st_r == irpa_pkg::HS_IDLE) begin
      if (launch) begin
        // Address and control bytes are forwarded exactly as software wrote them
        tx_r <= wb_dat_i[7:0];
        stop_f_r <= wb_dat_i[irpa_pkg::CMD_STOP];
        read_f_r <= wb_dat_i[irpa_pkg::CMD_READ];
        nack_f_r <= wb_dat_i[irpa_pkg::CMD_NACK];
        st_r <= wb_dat_i[irpa_pkg::CMD_START] ? irpa_pkg::HS_START : irpa_pkg::HS_BIT;
        ph_r <= 2'h0;
        bit_r <= 4'h0;
        tmr_r <= irpa_pkg::HALF_M1;
      end
    end else if (tmr_r != 6'h00) begin
      tmr_r <= tmr_r - 6'h01;
    end else begin
      tmr_r <= irpa_pkg::HALF_M1;
      ph_r <= ph_r + 2'h1;
      case (st_r)
        irpa_pkg::HS_START: begin
          if (ph_r == 2'h3) begin
            st_r <= irpa_pkg::HS_BIT;
            ph_r <= 2'h0;
          end
        end
        irpa_pkg::HS_BIT: begin
          if (ph_r == 2'h1) begin
            ph_r <= 2'h0;
            bit_r <= bit_r + 4'h1;
            // Sample at the end of the clock high time
            if (bit_r != irpa_pkg::BYTE_DONE) begin
              rx_r <= {rx_r[6:0], link.sda};
            end else begin
              if (!read_f_r) begin
                nack_seen_r <= link.sda;
              end
              st_r <= stop_f_r ? irpa_pkg::HS_STOP : irpa_pkg::HS_IDLE;
              held_r <= 1'b1;
            end
          end
        end
        irpa_pkg::HS_STOP: begin
          if (ph_r == 2'h2) begin
            st_r <= irpa_pkg::HS_IDLE;
            held_r <= 1'b0;
          end
        end
        default: st_r <= irpa_pkg::HS_IDLE;
      endcase
    end
  end

  assign link.scl_m_o = 1'b0;
  assign link.scl_m_oe = scl_low_r;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = sda_low_r;
endmodule

// *** dv/irpa_checker.sv ***
// Assertions on the two-wire link and the device pointer control.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module irpa_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda_s_oe,
  input wire logic [7:0] pointer_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Scheme and index views; the scheme must only move at capture or stop
  wire logic [2:0] sch = pointer_i[7:5];
  wire logic [4:0] idx = pointer_i[4:0];

  property p_sda_low_scl; $changed(sda_s_oe) |-> !scl; endproperty
  a_sda_low_scl: assert property (p_sda_low_scl) else $error("sda moved with scl high");
  property p_scheme_hold; $changed(sch) |-> scl; endproperty
  a_scheme_hold: assert property (p_scheme_hold) else $error("scheme moved off scl high");
  property p_index_rise; $changed(idx) |-> scl; endproperty
  a_index_rise: assert property (p_index_rise) else $error("index moved off scl high");
  // Plain step, turning points excluded
  property p_step_one;
    sch[2] && $stable(sch) && $changed(idx) && $past(idx) != 5'h1b
      && !($past(idx) == 5'h11 && sch == 3'h5) && !($past(idx) == 5'h13 && sch[1])
      |-> idx == $past(idx) + 5'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("index step not one");
  property p_wrap_all; sch == 3'h4 && $stable(sch) && $past(idx) == 5'h1b && $changed(idx) |->
    idx == 5'h00; endproperty
  a_wrap_all: assert property (p_wrap_all) else $error("wrap all wrong");
  property p_wrap_bright; sch == 3'h5 && $stable(sch) && $past(idx) == 5'h11 && $changed(idx) |->
    idx == 5'h02; endproperty
  a_wrap_bright: assert property (p_wrap_bright) else $error("wrap bright wrong");
  property p_wrap_group; sch == 3'h6 && $stable(sch) && $past(idx) == 5'h13 && $changed(idx) |->
    idx == 5'h12; endproperty
  a_wrap_group: assert property (p_wrap_group) else $error("wrap group wrong");
  property p_wrap_both; sch == 3'h7 && $stable(sch) && $past(idx) == 5'h13 && $changed(idx) |->
    idx == 5'h02; endproperty
  a_wrap_both: assert property (p_wrap_both) else $error("wrap both wrong");
endmodule

// *** dv/testbench.sv ***
// Bench: Wishbone drives the bus master, which talks to the register front end.
// Assumes the master and device share clk_i; each scenario after sc_reset starts from a soft reset call.
`timescale 1ns/1ns
module testbench;
  localparam logic [6:0] DEV_ADDR = 7'h20;
  logic clk_i;
  logic rst_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic wb_ack;
  logic [7:0] wb_adr;
  logic [31:0] wb_wdat;
  logic [3:0] wb_sel;
  logic [31:0] wb_rdat;
  logic [7:0] fault;
  logic [irpa_pkg::REG_COUNT-1:0][7:0] regs;
  logic [7:0] ptr;
  int num_errors;
  int n_compared;

  irpa_link_if link();
  irpa_host irpa_host_i(.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  irpa_device irpa_device_i(.clk_i(clk_i), .rst_i(rst_i), .link(link), .slave_addr_i(DEV_ADDR),
    .fault_i(fault), .regs_o(regs), .pointer_o(ptr));
  irpa_checker irpa_checker_i(.clk_i(clk_i), .rst_i(rst_i), .scl(link.scl),
    .sda_s_oe(link.sda_s_oe), .pointer_i(ptr));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      num_errors++;
      $display("unexpected wb ack expected 1 seen %b", wb_ack);
      conclude();
    end
  endtask

  // Issue a command, then poll busy with a bound; a stuck link ends the run
  task automatic cmd(input logic [31:0] c, output logic [31:0] st);
    int n;
    n = 0;
    wb(1'b1, irpa_pkg::WB_CMD, c, st);
    do begin
      wb(1'b0, irpa_pkg::WB_STAT, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 1000);
    if (st[0] !== 1'b0) begin
      num_errors++;
      $display("unexpected busy expected 0 seen %b", st[0]);
      conclude();
    end
  endtask

  task automatic put(input logic [7:0] b, input logic s, input logic p, input logic nk);
    logic [31:0] st;
    cmd({20'h0, 1'b0, 1'b0, p, s, b}, st);
    chk("nack flag", {7'h0, nk}, {7'h0, st[1]});
  endtask

  task automatic get(input logic nk, input logic p, input logic [7:0] exp);
    logic [31:0] st;
    cmd({20'h0, nk, 1'b1, p, 1'b0, 8'hff}, st);
    chk("read byte", exp, st[15:8]);
  endtask

  task automatic soft_rst;
    put({irpa_pkg::SOFT_RESET_ADDR, 1'b0}, 1'b1, 1'b1, 1'b0);
  endtask

  // Write transaction: address, control byte, two data bytes, stop
  task automatic wr_txn(input logic [7:0] ctl, input logic [7:0] a, input logic [7:0] b);
    put({DEV_ADDR, 1'b0}, 1'b1, 1'b0, 1'b0);
    put(ctl, 1'b0, 1'b0, 1'b0);
    put(a, 1'b0, 1'b0, 1'b0);
    put(b, 1'b0, 1'b1, 1'b0);
  endtask

  task automatic sc_reset;
    logic [31:0] r;
    for (int i = 0; i < irpa_pkg::REG_COUNT; i++) begin
      chk("reset value", irpa_pkg::REG_RST[i], regs[i]);
    end
    chk("broadcast reset", 8'h90, regs[17]);
    chk("pointer reset", 8'h00, ptr);
    put(8'h92, 1'b1, 1'b1, 1'b1);
    put(8'h91, 1'b1, 1'b0, 1'b0);
    get(1'b1, 1'b1, 8'h11);
    put(8'h90, 1'b1, 1'b1, 1'b0);
    wb(1'b1, 8'h10, 32'h0000_00ff, r);
    wb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped read", 8'h00, r[7:0]);
  endtask

  task automatic sc_soft;
    soft_rst();
    wr_txn(8'h02, 8'hee, 8'h4d);
    chk("fixed target", 8'h4d, regs[2]);
    chk("fixed neighbour", 8'h00, regs[3]);
    chk("fixed pointer", 8'h02, ptr);
    put({irpa_pkg::SOFT_RESET_ADDR, 1'b1}, 1'b1, 1'b1, 1'b1);
    chk("kept on read call", 8'h4d, regs[2]);
    soft_rst();
    chk("cleared by call", 8'h00, regs[2]);
    chk("pointer cleared", 8'h00, ptr);
  endtask

  // Each scheme starts at its turning point; the second byte lands past the wrap
  task automatic sc_wrap;
    logic [7:0] ctl [4];
    logic [4:0] nxt [4];
    ctl = '{8'h9b, 8'hb1, 8'hd3, 8'hf3};
    nxt = '{5'h00, 5'h02, 5'h12, 5'h02};
    for (int i = 0; i < 4; i++) begin
      soft_rst();
      wr_txn(ctl[i], 8'ha5, 8'h3c);
      chk("wrapped target", 8'h3c, regs[nxt[i]]);
      chk("wrapped pointer", {ctl[i][7:5], nxt[i] + 5'h01}, ptr);
      // Only the brightness scheme starts on a writable register; the next call resets it
      if (i == 1) begin
        chk("first target", 8'ha5, regs[17]);
      end
    end
  endtask

  task automatic sc_read;
    soft_rst();
    put({DEV_ADDR, 1'b0}, 1'b1, 1'b0, 1'b0);
    put(8'h92, 1'b0, 1'b0, 1'b0);
    put(8'h77, 1'b0, 1'b1, 1'b0);
    chk("gain written", 8'h77, regs[18]);
    put({DEV_ADDR, 1'b1}, 1'b1, 1'b0, 1'b0);
    get(1'b0, 1'b0, 8'h5a);
    get(1'b0, 1'b0, 8'h00);
    get(1'b1, 1'b1, 8'h00);
    chk("read pointer", 8'h96, ptr);
  endtask

  // Reset for ten cycles, then the scenarios in turn
  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    wb_sel = 4'h0;
    fault = 8'h5a;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_soft();
    sc_wrap();
    sc_read();
    conclude();
  end
endmodule
